// [src/fwac_top.sv]
`include "fwac_cfg.svh"
`default_nettype none

// Operation
// - program write enable low: external data writes go to external ram, except writes to the i/o control register address.
// - enable high: movx @dptr,a writes accumulator byte to flash at dptr.
// - hardware clears program write enable after each flash byte write.
// - writes to program write enable ignored while interrupts globally enabled.
// - flash readable status is the inverse of the security setting.
// - unlock field must hold 2; otherwise every flash modification is refused.
// - read-only status shows whether ports may currently write flash.
// - posted mode with engine on holds one write until engine busy falls.
// - while a posted write is pending, flag set and further writes discarded.
module fwac_top #(
  parameter int ADDR_W = 16
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              reset,
  // special function register access from the core
  input  wire logic [7:0]        sfr_addr,
  input  wire logic              sfr_wr,
  input  wire logic              sfr_rd,
  input  wire logic [7:0]        sfr_wdata,
  output logic      [7:0]        sfr_rdata_ff,
  // external data move access from the core
  input  wire logic [ADDR_W-1:0] xdat_addr,
  input  wire logic              xdat_wr,
  input  wire logic              xdat_rd,
  input  wire logic              xdat_via_dptr,
  input  wire logic [7:0]        xdat_wdata,
  output logic      [7:0]        xdat_rdata_ff,
  // core state
  input  wire logic              irq_global_en,
  // external ram side
  output logic                   ram_we_ff,
  output logic                   ram_rd_ff,
  output logic      [ADDR_W-1:0] ram_addr_ff,
  output logic      [7:0]        ram_wdata_ff,
  // flash programming side
  output logic                   flash_we_ff,
  output logic      [ADDR_W-1:0] flash_addr_ff,
  output logic      [7:0]        flash_wdata_ff,
  // compute engine and security
  input  wire logic              ce_enable,
  input  wire logic              ce_busy,
  input  wire logic              security_setting,
  // port access status toward emulator_port and spi slave
  output logic                   flash_port_readable_status_ff,
  output logic                   flash_port_writable_status_ff
);

  // ****************************************************************
  // parameter check
  // ****************************************************************
  if (ADDR_W < 16)
  begin : g_bad_addr_w
    $error("ADDR_W must be at least 16");
  end

  // ****************************************************************
  // state
  // ****************************************************************
  logic       program_write_enable_ff;
  logic       nxt_program_write_enable;
  logic       posted_write_enable_ff;
  logic [3:0] flash_modify_unlock_ff;

  fwac_queue_if #(.ADDR_W(ADDR_W)) fq ();

  // ****************************************************************
  // decode
  // ****************************************************************
  wire sfr_hit     = (sfr_addr == `FWAC_SFR_CTRL_ADR);
  wire sfr_wr_hit  = sfr_wr && sfr_hit;
  wire pwe_wr_ok   = sfr_wr_hit && !irq_global_en;
  wire io_hit      = (xdat_addr == ADDR_W'(`FWAC_IO_CTRL_ADR));
  wire flash_path  = xdat_wr && program_write_enable_ff && xdat_via_dptr;
  wire io_wr_hit   = xdat_wr && !flash_path && io_hit;
  wire ram_wr_sel  = xdat_wr && !flash_path && !io_hit;
  wire ram_rd_sel  = xdat_rd && !io_hit;
  wire unlocked    = (flash_modify_unlock_ff == `FWAC_UNLOCK_KEY);
  wire port_wr_ok  = unlocked && !security_setting;

  wire [7:0] sfr_rd_word = {4'h0, fq.pending, posted_write_enable_ff,
                            1'b0, program_write_enable_ff};
  wire [7:0] io_rd_word  = {flash_modify_unlock_ff, 1'b0,
                            !security_setting, port_wr_ok, 1'b0};

  always_comb
  begin
    nxt_program_write_enable = program_write_enable_ff;
    if (pwe_wr_ok)
      nxt_program_write_enable = sfr_wdata[`FWAC_PWE_BIT];
    else if (flash_path)
      nxt_program_write_enable = 1'b0;
  end

  // ****************************************************************
  // posted write queue
  // ****************************************************************
  assign fq.req_valid = flash_path && unlocked;
  assign fq.req_addr  = xdat_addr;
  assign fq.req_data  = xdat_wdata;
  assign fq.post_en   = posted_write_enable_ff;
  assign fq.ce_enable = ce_enable;
  assign fq.ce_busy   = ce_busy;

  fwac_post_queue #(
    .ADDR_W (ADDR_W)
  ) u_queue (
    .sys_clk (sys_clk),
    .reset   (reset),
    .q       (fq.queue)
  );

  // ****************************************************************
  // control registers
  // ****************************************************************
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      program_write_enable_ff <= `FWAC_PWE_RST;
      posted_write_enable_ff  <= `FWAC_POST_RST;
      flash_modify_unlock_ff  <= `FWAC_UNLOCK_RST;
    end
    else
    begin
      program_write_enable_ff <= nxt_program_write_enable;
      if (sfr_wr_hit)
        posted_write_enable_ff <= sfr_wdata[`FWAC_POST_BIT];
      if (io_wr_hit)
        flash_modify_unlock_ff <= xdat_wdata[`FWAC_UNLOCK_MSB:`FWAC_UNLOCK_LSB];
    end
  end

  // ****************************************************************
  // read data and status
  // ****************************************************************
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      sfr_rdata_ff                  <= 8'h00;
      xdat_rdata_ff                 <= 8'h00;
      flash_port_readable_status_ff <= 1'b0;
      flash_port_writable_status_ff <= 1'b0;
    end
    else
    begin
      if (sfr_rd && sfr_hit)
        sfr_rdata_ff <= sfr_rd_word;
      if (xdat_rd && io_hit)
        xdat_rdata_ff <= io_rd_word;
      flash_port_readable_status_ff <= !security_setting;
      flash_port_writable_status_ff <= port_wr_ok;
    end
  end

  // ****************************************************************
  // ram and flash strobes
  // ****************************************************************
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      ram_we_ff      <= 1'b0;
      ram_rd_ff      <= 1'b0;
      ram_addr_ff    <= '0;
      ram_wdata_ff   <= 8'h00;
      flash_we_ff    <= 1'b0;
      flash_addr_ff  <= '0;
      flash_wdata_ff <= 8'h00;
    end
    else
    begin
      ram_we_ff      <= ram_wr_sel;
      ram_rd_ff      <= ram_rd_sel;
      ram_addr_ff    <= xdat_addr;
      ram_wdata_ff   <= xdat_wdata;
      flash_we_ff    <= fq.issue;
      flash_addr_ff  <= fq.issue_addr;
      flash_wdata_ff <= fq.issue_data;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_ram_route_default: assert property (@(posedge sys_clk) disable iff (reset)
    xdat_wr && !program_write_enable_ff && !io_hit |=> ram_we_ff && !flash_path)
    else $error("ram write not routed to ram");

  chk_flash_write_map: assert property (@(posedge sys_clk) disable iff (reset)
    flash_path && unlocked && !fq.pending && !(posted_write_enable_ff && ce_enable)
      |-> ##2 flash_we_ff && flash_addr_ff == $past(xdat_addr, 2)
        && flash_wdata_ff == $past(xdat_wdata, 2) && !ram_we_ff)
    else $error("flash byte write wrong");

  chk_pwe_self_clear: assert property (@(posedge sys_clk) disable iff (reset)
    flash_path && !pwe_wr_ok |=> !program_write_enable_ff)
    else $error("program write enable not cleared");

  chk_pwe_irq_lock: assert property (@(posedge sys_clk) disable iff (reset)
    sfr_wr_hit && irq_global_en && !flash_path
      |=> program_write_enable_ff == $past(program_write_enable_ff))
    else $error("enable changed while interrupts on");

  chk_readable_inverse: assert property (@(posedge sys_clk) disable iff (reset)
    !reset |=> flash_port_readable_status_ff == !$past(security_setting))
    else $error("readable status not inverse of security");

  chk_unlock_gate: assert property (@(posedge sys_clk) disable iff (reset)
    flash_path && !unlocked && !fq.pending && !fq.issue |-> ##2 !flash_we_ff)
    else $error("locked flash write issued");

  chk_writable_status: assert property (@(posedge sys_clk) disable iff (reset)
    !reset |=> flash_port_writable_status_ff
      == ($past(flash_modify_unlock_ff) == `FWAC_UNLOCK_KEY && !$past(security_setting)))
    else $error("writable status wrong");

  chk_locked_clear: assert property (@(posedge sys_clk) disable iff (reset)
    flash_path && !unlocked |-> !fq.req_valid ##1 !program_write_enable_ff)
    else $error("locked write not dropped or enable kept");

  chk_pend_readback: assert property (@(posedge sys_clk) disable iff (reset)
    sfr_rd && sfr_hit |=> sfr_rdata_ff[`FWAC_PEND_BIT] == $past(fq.pending))
    else $error("pending flag readback wrong");

endmodule : fwac_top

`default_nettype wire

// [shared/fwac_cfg.svh]
`ifndef FWAC_CFG_SVH
`define FWAC_CFG_SVH

// ****************************************************************
// register locations
// ****************************************************************
`define FWAC_SFR_CTRL_ADR      8'hb2
`define FWAC_IO_CTRL_ADR       16'h2702

// ****************************************************************
// field positions, special function register
// ****************************************************************
`define FWAC_PWE_BIT           0
`define FWAC_POST_BIT          2
`define FWAC_PEND_BIT          3

// ****************************************************************
// field positions, i/o register
// ****************************************************************
`define FWAC_WRE_BIT           1
`define FWAC_RDE_BIT           2
`define FWAC_UNLOCK_LSB        4
`define FWAC_UNLOCK_MSB        7

// ****************************************************************
// values
// ****************************************************************
`define FWAC_UNLOCK_KEY        4'h2
`define FWAC_UNLOCK_RST        4'h0
`define FWAC_PWE_RST           1'b0
`define FWAC_POST_RST          1'b0

`endif

// [shared/fwac_pkg.sv]
`default_nettype none

package fwac_pkg;

  // posted write queue states, gray along idle -> held
  typedef enum logic [1:0] {
    FWAC_Q_IDLE = 2'b00,
    FWAC_Q_HELD = 2'b01
  } fwac_qstate_t;

endpackage : fwac_pkg

`default_nettype wire

// [shared/fwac_queue_if.sv]
`default_nettype none

interface fwac_queue_if #(
  parameter int ADDR_W = 16
);
  logic              req_valid;
  logic [ADDR_W-1:0] req_addr;
  logic [7:0]        req_data;
  logic              post_en;
  logic              ce_enable;
  logic              ce_busy;
  logic              pending;
  logic              issue;
  logic [ADDR_W-1:0] issue_addr;
  logic [7:0]        issue_data;

  modport ctrl (
    output req_valid, req_addr, req_data, post_en, ce_enable, ce_busy,
    input  pending, issue, issue_addr, issue_data
  );

  modport queue (
    input  req_valid, req_addr, req_data, post_en, ce_enable, ce_busy,
    output pending, issue, issue_addr, issue_data
  );
endinterface : fwac_queue_if

`default_nettype wire

// [src/fwac_post_queue.sv]
`include "fwac_cfg.svh"
`default_nettype none

module fwac_post_queue #(
  parameter int ADDR_W = 16
) (
  // clock and reset
  input  wire logic    sys_clk,
  input  wire logic    reset,
  // request side and issue side
  fwac_queue_if.queue  q
);

  fwac_pkg::fwac_qstate_t state_ff;
  fwac_pkg::fwac_qstate_t nxt_state;
  logic [ADDR_W-1:0]      held_addr_ff;
  logic [7:0]             held_data_ff;
  logic                   busy_q_ff;
  logic                   issue_ff;
  logic [ADDR_W-1:0]      issue_addr_ff;
  logic [7:0]             issue_data_ff;

  // ****************************************************************
  // decode
  // ****************************************************************
  wire held      = (state_ff == fwac_pkg::FWAC_Q_HELD);
  wire post_mode = q.post_en && q.ce_enable;
  wire busy_fall = busy_q_ff && !q.ce_busy;
  wire drain     = held && (busy_fall || !post_mode);
  wire take      = q.req_valid && !held;
  wire store     = take && post_mode;
  wire direct    = take && !post_mode;

  assign q.pending    = held;
  assign q.issue      = issue_ff;
  assign q.issue_addr = issue_addr_ff;
  assign q.issue_data = issue_data_ff;

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      fwac_pkg::FWAC_Q_IDLE: if (store) nxt_state = fwac_pkg::FWAC_Q_HELD;
      fwac_pkg::FWAC_Q_HELD: if (drain) nxt_state = fwac_pkg::FWAC_Q_IDLE;
      default:               nxt_state = fwac_pkg::FWAC_Q_IDLE;
    endcase
  end

  // ****************************************************************
  // storage
  // ****************************************************************
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      state_ff  <= fwac_pkg::FWAC_Q_IDLE;
      busy_q_ff <= 1'b0;
      issue_ff  <= 1'b0;
    end
    else
    begin
      state_ff  <= nxt_state;
      busy_q_ff <= q.ce_busy;
      issue_ff  <= direct || drain;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      held_addr_ff  <= '0;
      held_data_ff  <= 8'h00;
      issue_addr_ff <= '0;
      issue_data_ff <= 8'h00;
    end
    else
    begin
      if (store)
      begin
        held_addr_ff <= q.req_addr;
        held_data_ff <= q.req_data;
      end
      if (drain)
      begin
        issue_addr_ff <= held_addr_ff;
        issue_data_ff <= held_data_ff;
      end
      else if (direct)
      begin
        issue_addr_ff <= q.req_addr;
        issue_data_ff <= q.req_data;
      end
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_post_hold: assert property (@(posedge sys_clk) disable iff (reset)
    store |=> held && !issue_ff)
    else $error("posted write not held");

  chk_drain_fall: assert property (@(posedge sys_clk) disable iff (reset)
    held && busy_q_ff && !q.ce_busy |=> issue_ff && !held
      && issue_addr_ff == $past(held_addr_ff))
    else $error("held write not issued on busy fall");

  chk_discard_busy: assert property (@(posedge sys_clk) disable iff (reset)
    held && q.req_valid && !drain |=> held && $stable(held_addr_ff) && !issue_ff)
    else $error("write accepted while pending");

endmodule : fwac_post_queue

`default_nettype wire

// [testbench/fwac_ce_model.sv]
`default_nettype none

module fwac_ce_model #(
  parameter int BUSY_LEN = 40
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic reset,
  // bench control
  input  wire logic start,
  // engine status
  output logic      ce_busy
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;

  // busy stays up while the countdown runs, then falls once
  assign nxt_cnt = start ? 8'(BUSY_LEN) : ((cnt_ff != 8'h00) ? cnt_ff - 8'h01 : 8'h00);
  assign ce_busy = (cnt_ff != 8'h00);

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      cnt_ff <= 8'h00;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
    end
  end
endmodule : fwac_ce_model

`default_nettype wire

// [testbench/test_flash_write_access_control.sv]
`include "fwac_cfg.svh"
`default_nettype none

module test_flash_write_access_control;
  timeunit 1ns;
  timeprecision 1ns;

  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  sfr_addr = 8'h00;
  logic        sfr_wr = 1'b0;
  logic        sfr_rd = 1'b0;
  logic [7:0]  sfr_wdata = 8'h00;
  logic [7:0]  sfr_rdata_ff;
  logic [15:0] xdat_addr = 16'h0000;
  logic        xdat_wr = 1'b0;
  logic        xdat_rd = 1'b0;
  logic        xdat_via_dptr = 1'b0;
  logic [7:0]  xdat_wdata = 8'h00;
  logic [7:0]  xdat_rdata_ff;
  logic        irq_global_en = 1'b0;
  logic        ram_we_ff;
  logic        ram_rd_ff;
  logic [15:0] ram_addr_ff;
  logic [7:0]  ram_wdata_ff;
  logic        flash_we_ff;
  logic [15:0] flash_addr_ff;
  logic [7:0]  flash_wdata_ff;
  logic        ce_enable = 1'b0;
  logic        ce_busy;
  logic        ce_start = 1'b0;
  logic        security_setting = 1'b0;
  logic        flash_port_readable_status_ff;
  logic        flash_port_writable_status_ff;
  int          err_count = 0;
  int          compares = 0;
  int          flash_cnt = 0;
  int          ram_cnt = 0;

  always #5 sys_clk = ~sys_clk;

  fwac_top #(.ADDR_W(16)) u_fwac_top (
    .sys_clk, .reset, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata_ff,
    .xdat_addr, .xdat_wr, .xdat_rd, .xdat_via_dptr, .xdat_wdata, .xdat_rdata_ff,
    .irq_global_en, .ram_we_ff, .ram_rd_ff, .ram_addr_ff, .ram_wdata_ff,
    .flash_we_ff, .flash_addr_ff, .flash_wdata_ff, .ce_enable, .ce_busy,
    .security_setting, .flash_port_readable_status_ff, .flash_port_writable_status_ff
  );

  fwac_ce_model #(.BUSY_LEN(40)) u_fwac_ce_model (
    .sys_clk, .reset, .start(ce_start), .ce_busy
  );

  // counts strobes seen at each edge
  always @(posedge sys_clk)
  begin
    if (flash_we_ff === 1'b1) flash_cnt++;
    if (ram_we_ff === 1'b1) ram_cnt++;
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask : chk

  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge sys_clk);
    sfr_wr <= 1'b0;
  endtask : sfr_write

  task automatic sfr_read(input logic [7:0] exp);
    @(posedge sys_clk);
    sfr_addr <= `FWAC_SFR_CTRL_ADR;
    sfr_rd <= 1'b1;
    @(posedge sys_clk);
    sfr_rd <= 1'b0;
    #1 chk("sfr read", exp, sfr_rdata_ff);
  endtask : sfr_read

  task automatic io_read(input logic [7:0] exp);
    @(posedge sys_clk);
    xdat_addr <= `FWAC_IO_CTRL_ADR;
    xdat_rd <= 1'b1;
    @(posedge sys_clk);
    xdat_rd <= 1'b0;
    #1 chk("io read", exp, xdat_rdata_ff);
  endtask : io_read

  task automatic xwrite(input logic [15:0] a, input logic [7:0] d, input logic via);
    @(posedge sys_clk);
    xdat_addr <= a;
    xdat_wdata <= d;
    xdat_via_dptr <= via;
    xdat_wr <= 1'b1;
    @(posedge sys_clk);
    xdat_wr <= 1'b0;
    xdat_via_dptr <= 1'b0;
  endtask : xwrite

  // called in the time step of the edge that took the write or saw busy low
  task automatic flash_expect(input logic [15:0] a, input logic [7:0] d);
    #1 chk("flash strobe early", 16'h0000, 16'(flash_we_ff));
    @(posedge sys_clk);
    #1 chk("flash strobe", 16'h0001, 16'(flash_we_ff));
    chk("flash addr", a, flash_addr_ff);
    chk("flash data", 16'(d), 16'(flash_wdata_ff));
  endtask : flash_expect

  task automatic print_verdict();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset_and_ram();
    sfr_read(8'h00);
    io_read(8'h04);
    xwrite(16'h1234, 8'h55, 1'b1);
    #1 chk("ram strobe", 16'h0001, 16'(ram_we_ff));
    chk("ram addr", 16'h1234, ram_addr_ff);
    chk("ram data", 16'h0055, 16'(ram_wdata_ff));
    repeat (3) @(posedge sys_clk);
    #1 chk("flash count", 16'h0000, 16'(flash_cnt));
    @(posedge sys_clk);
    xdat_addr <= 16'h0040;
    xdat_rd <= 1'b1;
    @(posedge sys_clk);
    xdat_rd <= 1'b0;
    #1 chk("ram read strobe", 16'h0001, 16'(ram_rd_ff));
    chk("ram read addr", 16'h0040, ram_addr_ff);
    @(posedge sys_clk);
    #1 chk("ram read strobe end", 16'h0000, 16'(ram_rd_ff));
  endtask : t_reset_and_ram

  task automatic t_irq_and_locked();
    int r0;
    sfr_write(`FWAC_SFR_CTRL_ADR, 8'h01);
    irq_global_en <= 1'b1;
    sfr_write(`FWAC_SFR_CTRL_ADR, 8'h00);
    sfr_read(8'h01);
    @(posedge sys_clk);
    irq_global_en <= 1'b0;
    r0 = ram_cnt;
    xwrite(16'h0100, 8'ha5, 1'b1);
    repeat (3) @(posedge sys_clk);
    #1 chk("locked flash count", 16'h0000, 16'(flash_cnt));
    chk("locked ram count", 16'(r0), 16'(ram_cnt));
    sfr_read(8'h00);
  endtask : t_irq_and_locked

  task automatic t_unlocked_write();
    int r0;
    xwrite(`FWAC_IO_CTRL_ADR, 8'h20, 1'b0);
    repeat (2) @(posedge sys_clk);
    #1 chk("writable", 16'h0001, 16'(flash_port_writable_status_ff));
    io_read(8'h26);
    sfr_write(`FWAC_SFR_CTRL_ADR, 8'h01);
    xwrite(16'h0100, 8'ha5, 1'b1);
    flash_expect(16'h0100, 8'ha5);
    sfr_read(8'h00);
    r0 = ram_cnt;
    xwrite(16'h0102, 8'h11, 1'b1);
    repeat (3) @(posedge sys_clk);
    #1 chk("no fresh enable flash", 16'h0001, 16'(flash_cnt));
    chk("no fresh enable ram", 16'(r0 + 1), 16'(ram_cnt));
  endtask : t_unlocked_write

  task automatic t_security();
    @(posedge sys_clk);
    security_setting <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 chk("readable", 16'h0000, 16'(flash_port_readable_status_ff));
    chk("writable", 16'h0000, 16'(flash_port_writable_status_ff));
    io_read(8'h20);
    @(posedge sys_clk);
    security_setting <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 chk("readable", 16'h0001, 16'(flash_port_readable_status_ff));
  endtask : t_security

  task automatic t_posted();
    int n;
    @(posedge sys_clk);
    ce_enable <= 1'b1;
    ce_start <= 1'b1;
    @(posedge sys_clk);
    ce_start <= 1'b0;
    sfr_write(`FWAC_SFR_CTRL_ADR, 8'h05);
    xwrite(16'h0100, 8'ha5, 1'b1);
    sfr_read(8'h0c);
    sfr_write(`FWAC_SFR_CTRL_ADR, 8'h05);
    xwrite(16'h0200, 8'h3c, 1'b1);
    sfr_read(8'h0c);
    chk("held flash count", 16'h0001, 16'(flash_cnt));
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (ce_busy !== 1'b0 && n < 100);
    chk("busy wait", 16'h0001, 16'(n < 100));
    flash_expect(16'h0100, 8'ha5);
    repeat (3) @(posedge sys_clk);
    #1 chk("drained flash count", 16'h0002, 16'(flash_cnt));
    sfr_read(8'h04);
    sfr_write(`FWAC_SFR_CTRL_ADR, 8'h00);
    ce_enable <= 1'b0;
  endtask : t_posted

  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial
  begin
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (3) @(posedge sys_clk);
    t_reset_and_ram();
    t_irq_and_locked();
    t_unlocked_write();
    t_security();
    t_posted();
    print_verdict();
  end

  initial
  begin
    repeat (2000) @(posedge sys_clk);
    err_count++;
    print_verdict();
  end
endmodule : test_flash_write_access_control

`default_nettype wire
